// ### hdl/pwm_out_stage.v
// One PWM output stage: set at compare match, cleared at period match,
// with selectable active level.
// Assumes count, match strobes and polarity are synchronous to core_clk.
`timescale 1ns/1ps

module pwm_out_stage
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Timing events
  input wire running,
  input wire compare_hit,
  input wire period_hit,
  // Level control
  input wire polarity,
  // Waveform
  output reg level
);

  reg active_reg;

  // Active phase tracker; period match wins, so a compare equal to
  // the period yields a flat inactive output
  always @(posedge core_clk)
  begin
    if (rst)
      active_reg <= 1'b0;
    else if (running && period_hit)
      active_reg <= 1'b0;
    else if (running && compare_hit)
      active_reg <= 1'b1;
  end

  // Active level mapping: 1 means high active
  always @*
  begin
    level = polarity ? active_reg : ~active_reg;
  end

endmodule

// ### hdl/pwm_timer_channel.v
// Three-output PWM timer channel with period, compare and buffer
// registers, match status, interrupt request and a small output port.
// Assumes a single-cycle register port master on core_clk.
`timescale 1ns/1ps

`include "pwm_timer_consts.vh"

module pwm_timer_channel
#(
  parameter CNT_W = 16
)
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Interrupt
  output reg channel_irq,
  // PWM pins, three signals each
  output reg pwm_pin_b_o,
  output reg pwm_pin_b_oe,
  output reg pwm_pin_c_o,
  output reg pwm_pin_c_oe,
  output reg pwm_pin_d_o,
  output reg pwm_pin_d_oe,
  input wire pwm_pin_b_i,
  input wire pwm_pin_c_i,
  input wire pwm_pin_d_i
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  reg [CNT_W-1:0] period_reg;
  reg [CNT_W-1:0] compare_b_reg;
  reg [CNT_W-1:0] compare_c_reg;
  reg [CNT_W-1:0] compare_d_reg;
  reg [CNT_W-1:0] channel_counter_reg;
  reg [CNT_W-1:0] active_period_reg;
  reg [CNT_W-1:0] active_b_reg;
  reg [4:0] match_status_flags_reg;
  reg [4:0] status_seen_reg;
  reg [7:0] irq_request_flags_2h_reg;
  reg [7:0] irq_mask_flags_2h_reg;
  reg [7:0] count_start_control_reg;
  reg [1:0] mode_reg;
  reg [2:0] polarity_reg;
  reg [4:0] irq_enable_reg;
  reg [7:0] port1_output_latch_reg;
  reg [7:0] port1_direction_reg;

  wire count_run_bit;
  wire buffer_select_c;
  wire buffer_select_d;
  wire wr_status;
  wire wr_pend;
  wire [CNT_W-1:0] use_period;
  wire [CNT_W-1:0] use_b;
  wire period_hit;
  wire hit_b;
  wire hit_c;
  wire hit_d;
  wire wrap_hit;
  wire [4:0] events;
  wire [4:0] clr_ok;
  wire irq_event;
  wire lvl_b;
  wire lvl_c;
  wire lvl_d;

  assign count_run_bit = count_start_control_reg[`BIT_RUN];
  assign buffer_select_c = mode_reg[`BIT_BUF_C];
  assign buffer_select_d = mode_reg[`BIT_BUF_D];
  assign wr_status = reg_wr && (reg_addr == `OFS_STATUS);
  assign wr_pend = reg_wr && (reg_addr == `OFS_IRQ_FLAGS);

  // ------------------------------------------------------------------
  // Compare and match decode
  // ------------------------------------------------------------------
  // Buffered modes run from shadow copies loaded at period end
  assign use_period = buffer_select_c ? active_period_reg : period_reg;
  assign use_b = buffer_select_d ? active_b_reg : compare_b_reg;
  assign period_hit = (channel_counter_reg == use_period);
  assign hit_b = (channel_counter_reg == use_b);
  // Compare C drives pin C only when not acting as a buffer
  assign hit_c = !buffer_select_c &&
                 (channel_counter_reg == compare_c_reg);
  // Compare D drives pin D only when not acting as a buffer
  assign hit_d = !buffer_select_d &&
                 (channel_counter_reg == compare_d_reg);
  assign wrap_hit = (channel_counter_reg == {CNT_W{1'b1}}) && !period_hit;
  assign events = {wrap_hit, hit_d, hit_c, hit_b, period_hit} &
                  {5{count_run_bit}};
  assign irq_event = |(events & irq_enable_reg);

  // ------------------------------------------------------------------
  // Counter and buffer transfer
  // ------------------------------------------------------------------
  // Counter runs only while start bit is set; clears at period match
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      channel_counter_reg <= {CNT_W{1'b0}};
      active_period_reg <= `RST_GENERAL;
      active_b_reg <= `RST_GENERAL;
    end
    else if (count_run_bit)
    begin
      if (period_hit)
      begin
        channel_counter_reg <= {CNT_W{1'b0}};
        // Buffered values take over only at the period boundary
        active_period_reg <= buffer_select_c ? compare_c_reg
                                             : period_reg;
        active_b_reg <= buffer_select_d ? compare_d_reg
                                        : compare_b_reg;
      end
      else
      begin
        channel_counter_reg <= channel_counter_reg +
                               {{(CNT_W-1){1'b0}}, 1'b1};
        // Unbuffered shadows track the live registers, so turning a
        // buffer on mid-period never brings back a stale value
        if (!buffer_select_c)
          active_period_reg <= period_reg;
        if (!buffer_select_d)
          active_b_reg <= compare_b_reg;
      end
    end
    else
    begin
      // Stopped: keep shadows current so a fresh start uses new values
      active_period_reg <= buffer_select_c ? compare_c_reg : period_reg;
      active_b_reg <= buffer_select_d ? compare_d_reg : compare_b_reg;
    end
  end

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  // Plain read-write registers; all 16 bits of general registers kept
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      period_reg <= `RST_GENERAL;
      compare_b_reg <= `RST_GENERAL;
      compare_c_reg <= `RST_GENERAL;
      compare_d_reg <= `RST_GENERAL;
      count_start_control_reg <= `RST_BYTE;
      mode_reg <= 2'b00;
      polarity_reg <= 3'b000;
      irq_enable_reg <= 5'b00000;
      port1_output_latch_reg <= `RST_BYTE;
      port1_direction_reg <= `RST_PORT_DIR;
      irq_mask_flags_2h_reg <= `RST_IRQ_MASK;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `OFS_PERIOD: period_reg <= reg_wdata;
        `OFS_COMPARE_B: compare_b_reg <= reg_wdata;
        `OFS_COMPARE_C: compare_c_reg <= reg_wdata;
        `OFS_COMPARE_D: compare_d_reg <= reg_wdata;
        `OFS_START: count_start_control_reg <= reg_wdata[7:0];
        `OFS_MODE: mode_reg <= reg_wdata[1:0];
        `OFS_POLARITY: polarity_reg <= reg_wdata[2:0];
        `OFS_IRQ_ENABLE: irq_enable_reg <= reg_wdata[4:0];
        `OFS_PORT_LATCH: port1_output_latch_reg <= reg_wdata[7:0];
        `OFS_PORT_DIR: port1_direction_reg <= reg_wdata[7:0];
        `OFS_IRQ_MASK: irq_mask_flags_2h_reg <= reg_wdata[7:0];
        default: period_reg <= period_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Match status flags, read-then-write-zero clearing
  // ------------------------------------------------------------------
  // A flag only clears if it was seen at 1 by a status read; a new
  // match in the clearing cycle wins, so no event is lost
  assign clr_ok = wr_status ? (status_seen_reg & ~reg_wdata[4:0])
                            : 5'b00000;

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      match_status_flags_reg <= 5'b00000;
      status_seen_reg <= 5'b00000;
    end
    else
    begin
      match_status_flags_reg <= (match_status_flags_reg & ~clr_ok) |
                                events;
      if (reg_rd && (reg_addr == `OFS_STATUS))
        status_seen_reg <= match_status_flags_reg;
      else if (wr_status)
        status_seen_reg <= 5'b00000;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt request flag and output
  // ------------------------------------------------------------------
  // Pending bit is sticky; software may write it, event wins the clear
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_request_flags_2h_reg <= `RST_BYTE;
      channel_irq <= 1'b0;
    end
    else
    begin
      if (wr_pend)
        irq_request_flags_2h_reg <= reg_wdata[7:0] |
          {6'b000000, irq_event, 1'b0};
      else if (irq_event)
        irq_request_flags_2h_reg[`BIT_IRQ_PEND] <= 1'b1;
      channel_irq <= irq_request_flags_2h_reg[`BIT_IRQ_PEND] &&
                     !irq_mask_flags_2h_reg[`BIT_IRQ_MASK];
    end
  end

  // ------------------------------------------------------------------
  // Output stages
  // ------------------------------------------------------------------
  pwm_out_stage stage_b
  (
    .core_clk(core_clk),
    .rst(rst),
    .running(count_run_bit),
    .compare_hit(hit_b),
    .period_hit(period_hit),
    .polarity(polarity_reg[`BIT_POL_B]),
    .level(lvl_b)
  );

  pwm_out_stage stage_c
  (
    .core_clk(core_clk),
    .rst(rst),
    .running(count_run_bit),
    .compare_hit(hit_c),
    .period_hit(period_hit),
    .polarity(polarity_reg[`BIT_POL_C]),
    .level(lvl_c)
  );

  pwm_out_stage stage_d
  (
    .core_clk(core_clk),
    .rst(rst),
    .running(count_run_bit),
    .compare_hit(hit_d),
    .period_hit(period_hit),
    .polarity(polarity_reg[`BIT_POL_D]),
    .level(lvl_d)
  );

  // Registered pins; enables follow the direction bits (0 drives)
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      pwm_pin_b_o <= 1'b0;
      pwm_pin_c_o <= 1'b0;
      pwm_pin_d_o <= 1'b0;
      pwm_pin_b_oe <= 1'b0;
      pwm_pin_c_oe <= 1'b0;
      pwm_pin_d_oe <= 1'b0;
    end
    else
    begin
      pwm_pin_b_o <= lvl_b;
      pwm_pin_c_o <= lvl_c;
      pwm_pin_d_o <= lvl_d;
      pwm_pin_b_oe <= !port1_direction_reg[`PIN_B];
      pwm_pin_c_oe <= !port1_direction_reg[`PIN_C];
      pwm_pin_d_oe <= !port1_direction_reg[`PIN_D];
    end
  end

  // ------------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------------
  // Data valid one cycle after the strobe; unmapped reads give zero
  always @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `OFS_PERIOD: reg_rdata <= period_reg;
        `OFS_COMPARE_B: reg_rdata <= compare_b_reg;
        `OFS_COMPARE_C: reg_rdata <= compare_c_reg;
        `OFS_COMPARE_D: reg_rdata <= compare_d_reg;
        `OFS_STATUS: reg_rdata <= {11'h000, match_status_flags_reg};
        `OFS_IRQ_FLAGS: reg_rdata <= {8'h00, irq_request_flags_2h_reg};
        `OFS_IRQ_MASK: reg_rdata <= {8'h00, irq_mask_flags_2h_reg};
        `OFS_START: reg_rdata <= {8'h00, count_start_control_reg};
        `OFS_MODE: reg_rdata <= {14'h0000, mode_reg};
        `OFS_POLARITY: reg_rdata <= {13'h0000, polarity_reg};
        `OFS_IRQ_ENABLE: reg_rdata <= {11'h000, irq_enable_reg};
        // Pins B, C and D in input mode read back the pad, bit 7 in input mode reads zero; others the latch
        `OFS_PORT_LATCH: reg_rdata <= {8'h00,
          port1_direction_reg[7] ? 1'b0 : port1_output_latch_reg[7],
          port1_direction_reg[`PIN_D] ? pwm_pin_d_i :
            port1_output_latch_reg[`PIN_D],
          port1_direction_reg[`PIN_C] ? pwm_pin_c_i :
            port1_output_latch_reg[`PIN_C],
          port1_direction_reg[`PIN_B] ? pwm_pin_b_i :
            port1_output_latch_reg[`PIN_B],
          port1_output_latch_reg[3:0]};
        `OFS_PORT_DIR: reg_rdata <= {8'h00, port1_direction_reg};
        `OFS_COUNTER: reg_rdata <= channel_counter_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

endmodule

// ### hdl/pwm_timer_consts.vh
// Constants for the three-output PWM timer channel: register offsets,
// field positions and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef PWM_TIMER_CONSTS_VH
`define PWM_TIMER_CONSTS_VH

// ------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ------------------------------------------------------------------
`define ADDR_W 4
`define OFS_PERIOD 4'h0
`define OFS_COMPARE_B 4'h1
`define OFS_COMPARE_C 4'h2
`define OFS_COMPARE_D 4'h3
`define OFS_STATUS 4'h4
`define OFS_IRQ_FLAGS 4'h5
`define OFS_IRQ_MASK 4'h6
`define OFS_START 4'h7
`define OFS_MODE 4'h8
`define OFS_POLARITY 4'h9
`define OFS_IRQ_ENABLE 4'ha
`define OFS_PORT_LATCH 4'hb
`define OFS_PORT_DIR 4'hc
`define OFS_COUNTER 4'hd

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define BIT_MATCH_A 0
`define BIT_MATCH_B 1
`define BIT_MATCH_C 2
`define BIT_MATCH_D 3
`define BIT_WRAP 4
`define BIT_IRQ_PEND 1
`define BIT_IRQ_MASK 1
`define BIT_RUN 0
`define BIT_BUF_C 0
`define BIT_BUF_D 1
`define BIT_POL_B 0
`define BIT_POL_C 1
`define BIT_POL_D 2
`define BIT_IE_A 0
`define PIN_B 4
`define PIN_C 5
`define PIN_D 6

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_GENERAL 16'hffff
`define RST_PORT_DIR 8'hff
`define RST_IRQ_MASK 8'hff
`define RST_BYTE 8'h00

`endif

// ### test/pwm_pin_loads.sv
// Loads on the three PWM pins, each pad with a pull-up.
// Assumes the channel is the only driver of these pads.
`timescale 1ns/1ps
module pwm_pin_loads
(
  // Drive from the channel
  input wire [2:0] pin_o,
  input wire [2:0] pin_oe,
  // Pad levels back to the channel
  output wire [2:0] pad
);
  // Released pads settle high, never keep the last driven level
  assign pad = (pin_o & pin_oe) | ~pin_oe;
endmodule

// ### test/pwm_timer_chk.sv
// Checker for the PWM timer channel: register port, pins, interrupt.
// Assumes a bind to pwm_timer_channel; sees only its ports.
`timescale 1ns/1ps
`include "pwm_timer_consts.vh"
module pwm_timer_chk
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Interrupt and pins
  input wire channel_irq,
  input wire pwm_pin_b_o,
  input wire pwm_pin_b_oe,
  input wire pwm_pin_d_o
);
  reg run_sh;
  reg mask_sh;
  reg dir_b_sh;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Shadows of control bits, from port writes
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      run_sh <= 1'b0;
      mask_sh <= 1'b1;
      dir_b_sh <= 1'b1;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `OFS_START) run_sh <= reg_wdata[`BIT_RUN];
      if (reg_addr == `OFS_IRQ_MASK) mask_sh <= reg_wdata[1];
      if (reg_addr == `OFS_PORT_DIR) dir_b_sh <= reg_wdata[`PIN_B];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> !reg_rdata)
    else $error("read data not zero outside read cycle");
  a_general_readback: assert property (reg_wr && reg_addr == 4'h1 ##1
    reg_rd && reg_addr == 4'h1 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("compare B read back wrong");
  a_start_readback: assert property (reg_wr && reg_addr == 4'h7 ##1
    reg_rd && reg_addr == 4'h7 |=> reg_rdata[0] == run_sh)
    else $error("start bit read back wrong");
  a_stopped_pins_hold: assert property ((!run_sh && !reg_wr) [*4] |->
    $stable(pwm_pin_b_o) && $stable(pwm_pin_d_o))
    else $error("pin moved while stopped");
  a_counter_steps: assert property (run_sh && reg_rd && reg_addr == 4'hd
    ##1 run_sh && reg_rd && reg_addr == 4'hd |=>
    reg_rdata == $past(reg_rdata) + 16'h0001 || !reg_rdata)
    else $error("counter did not step or clear");
  a_mask_blocks_irq: assert property (reg_wr && reg_addr == 4'h6 &&
    reg_wdata[1] |=> ##1 !channel_irq)
    else $error("interrupt not blocked by mask");
  a_irq_needs_unmask: assert property (channel_irq |-> !$past(mask_sh))
    else $error("interrupt while masked");
  a_dir_sets_enable: assert property (reg_wr && reg_addr == 4'hc |=> ##1
    pwm_pin_b_oe != dir_b_sh)
    else $error("pin B enable does not follow direction");
endmodule

// ### test/timer_pwm_three_channel_test.sv
// Testbench for the PWM timer channel, register tasks and pin counts.
// Assumes pwm_timer_chk and pwm_pin_loads are compiled before it.
`timescale 1ns/1ps
`include "pwm_timer_consts.vh"
module timer_pwm_three_channel_test;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [15:0] reg_rdata;
  wire channel_irq;
  wire [2:0] pin_o;
  wire [2:0] pin_oe;
  wire [2:0] pad;
  integer miscompares = 0;
  integer checked = 0;
  integer cycles = 0;
  integer i;
  reg [15:0] v;
  reg [15:0] v2;
  reg [15:0] hb;
  reg [15:0] hc;
  reg [15:0] hd;
  // ----------------------------------------
  // Design, loads and clock
  // ----------------------------------------
  pwm_timer_channel uut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_irq(channel_irq),
    .pwm_pin_b_o(pin_o[0]), .pwm_pin_b_oe(pin_oe[0]),
    .pwm_pin_c_o(pin_o[1]), .pwm_pin_c_oe(pin_oe[1]),
    .pwm_pin_d_o(pin_o[2]), .pwm_pin_d_oe(pin_oe[2]),
    .pwm_pin_b_i(pad[0]), .pwm_pin_c_i(pad[1]), .pwm_pin_d_i(pad[2]));
  pwm_pin_loads loads (.pin_o(pin_o), .pin_oe(pin_oe), .pad(pad));
  always #5 core_clk = ~core_clk;
  // Hang guard, well above the roughly 1330 cycles of the run
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wreg(input [3:0] a, input [15:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Write then read with no gap; rd2 reads one place twice in a row
  task wrrd(input [3:0] a, input [15:0] d, output [15:0] q);
    begin
      wreg(a, d);
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
    end
  endtask
  task rd2(input [3:0] a, output [15:0] q1, output [15:0] q2);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      #1 q1 = reg_rdata;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q2 = reg_rdata;
    end
  endtask
  // Counts cycles in which each pin is high
  task measure(input integer n);
    begin
      hb = 0;
      hc = 0;
      hd = 0;
      repeat (n)
      begin
        @(posedge core_clk);
        #1;
        hb = hb + pin_o[0];
        hc = hc + pin_o[1];
        hd = hd + pin_o[2];
      end
    end
  endtask
  task complete_run;
    begin
      if (miscompares == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd2(`OFS_PERIOD, v, v2);
    check("period reset", v, `RST_GENERAL);
    rd2(`OFS_IRQ_MASK, v, v2);
    check("mask reset", v, {8'h00, `RST_IRQ_MASK});
    rd2(`OFS_PORT_LATCH, v, v2);
    check("released pads", v & 16'h0070, 16'h0070);
    rd2(4'he, v, v2);
    check("unmapped", v, 16'h0000);
    for (i = 0; i < 4; i = i + 1)
    begin
      wrrd(i[3:0], 16'h0000, v);
      check("general low", v, 16'h0000);
      wrrd(i[3:0], 16'hffff, v);
      check("general high", v, 16'hffff);
    end
    // Period of 100 counts, change points at 25, 50 and 75 percent
    wreg(`OFS_PERIOD, 16'd99);
    wreg(`OFS_COMPARE_B, 16'd24);
    wreg(`OFS_COMPARE_C, 16'd49);
    wreg(`OFS_COMPARE_D, 16'd74);
    wreg(`OFS_POLARITY, 16'h0007);
    wreg(`OFS_IRQ_ENABLE, 16'h0001);
    wreg(`OFS_IRQ_MASK, 16'h0000);
    wreg(`OFS_PORT_DIR, 16'h008f);
    wrrd(`OFS_START, 16'h0001, v);
    check("run bit", v & 16'h0001, 16'h0001);
    check("pins driven", {13'h0, pin_oe}, 16'h0007);
    rd2(`OFS_COUNTER, v, v2);
    check("count step", v2, (v == 16'd99) ? 16'h0 : v + 16'h1);
    repeat (200) @(posedge core_clk);
    measure(200);
    check("pin B high", hb, 16'd150);
    check("pin C high", hc, 16'd100);
    check("pin D high", hd, 16'd50);
    rd2(`OFS_STATUS, v, v2);
    check("match A", v & 16'h0001, 16'h0001);
    rd2(`OFS_IRQ_FLAGS, v, v2);
    check("pending", v & 16'h0002, 16'h0002);
    check("irq high", {15'h0, channel_irq}, 16'h0001);
    wreg(`OFS_POLARITY, 16'h0006);
    // Two whole periods, so the count does not depend on phase
    measure(200);
    check("pin B low active", hb, 16'd50);
    wreg(`OFS_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge core_clk);
    check("irq masked", {15'h0, channel_irq}, 16'h0000);
    wreg(`OFS_START, 16'h0000);
    repeat (4) @(posedge core_clk);
    rd2(`OFS_COUNTER, v, v2);
    check("stopped count", v2, v);
    // A clearing write without a fresh read must leave the flag set
    wreg(`OFS_STATUS, 16'h0001);
    wreg(`OFS_STATUS, 16'h0000);
    rd2(`OFS_STATUS, v, v2);
    check("no clear unread", v & 16'h0001, 16'h0001);
    wreg(`OFS_STATUS, 16'h0000);
    rd2(`OFS_STATUS, v, v2);
    check("clear after read", v & 16'h0001, 16'h0000);
    wreg(`OFS_IRQ_MASK, 16'h0000);
    wreg(`OFS_IRQ_FLAGS, 16'h0000);
    rd2(`OFS_IRQ_FLAGS, v, v2);
    check("pending cleared", v & 16'h0002, 16'h0000);
    wreg(`OFS_IRQ_ENABLE, 16'h0000);
    wreg(`OFS_START, 16'h0001);
    repeat (220) @(posedge core_clk);
    rd2(`OFS_IRQ_FLAGS, v, v2);
    check("disabled event", v & 16'h0002, 16'h0000);
    // Buffered period of 5 counts, then buffered change point for B
    wreg(`OFS_POLARITY, 16'h0007);
    wreg(`OFS_COMPARE_B, 16'd2);
    wreg(`OFS_COMPARE_C, 16'd4);
    wreg(`OFS_MODE, 16'h0001);
    repeat (250) @(posedge core_clk);
    measure(50);
    check("buffered period", hb, 16'd20);
    wreg(`OFS_COMPARE_D, 16'd1);
    wreg(`OFS_MODE, 16'h0003);
    repeat (20) @(posedge core_clk);
    measure(50);
    check("buffered point", hb, 16'd30);
    complete_run;
  end
endmodule
bind pwm_timer_channel pwm_timer_chk chk (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_irq(channel_irq),
  .pwm_pin_b_o(pwm_pin_b_o), .pwm_pin_b_oe(pwm_pin_b_oe),
  .pwm_pin_d_o(pwm_pin_d_o));
